// >>> src/dmsrp_params.svh
// Constants of the dual-mode serial register port: addresses, widths, timing.
`ifndef DMSRP_PARAMS_SVH
`define DMSRP_PARAMS_SVH
`define DMSRP_DEV_ADDR 7'h70
`define DMSRP_SUB_LAST_WR 8'h0f
`define DMSRP_SUB_STATUS 8'h80
`define DMSRP_SUB_ADC 8'h81
`define DMSRP_SUB_NARROW_A 8'h03
`define DMSRP_SUB_NARROW_B 8'h08
`define DMSRP_SUB_NARROW_C 8'h0d
`define DMSRP_SUB_NARROW_D 8'h0e
`define DMSRP_SUB_HOLE_LO 8'h09
`define DMSRP_SUB_HOLE_HI 8'h0c
`define DMSRP_BYTE_BITS 4'h8
`define DMSRP_LAST_BIT 4'h7
`define DMSRP_REF_PERIOD_NS 10
`define DMSRP_SCL_PERIOD_NS 1000
`define DMSRP_QUARTER_CYC ((`DMSRP_SCL_PERIOD_NS) / (4 * `DMSRP_REF_PERIOD_NS))
`endif

// >>> src/dmsrp_pkg.sv
// Types shared by both ends of the dual-mode serial register port.
`default_nettype none
`include "dmsrp_params.svh"
package dmsrp_pkg;
  // Device-side link protocol states.
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_SUB, D_WDATA, D_RACK, D_READ, D_DONE} dmsrp_dst_t;
  // Controller-side sequencer states.
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} dmsrp_hst_t;
  // Link-domain state of the device end.
  typedef struct packed {
    dmsrp_dst_t st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] sub;
    logic [7:0] hi;
    logic nb;
    logic [7:0] rd;
    logic plan;
    logic wr_tog;
    logic [3:0] h_addr;
    logic [15:0] h_data;
    logic h_wide;
    logic start_seen;
    logic stop_seen;
    logic en_seen;
    logic [15:0] stat_s1;
    logic [15:0] stat_s2;
  } dmsrp_dlink_t;
  // Reference-domain state of the device end.
  typedef struct packed {
    logic [2:0] tog_s;
    logic [1:0] en_s;
    logic [1:0] mode_s;
    logic pend;
    logic strobe;
    logic [3:0] addr;
    logic [15:0] data;
    logic wide;
  } dmsrp_dref_t;
  // Controller state.
  typedef struct packed {
    dmsrp_hst_t st;
    logic [1:0] q;
    logic [7:0] tick;
    logic scl;
    logic pull;
    logic en_n;
    logic mode;
    logic [31:0] bytes;
    logic [2:0] nbytes;
    logic [2:0] bi;
    logic [3:0] bitc;
    logic [7:0] rx;
    logic isrd;
    logic nack;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
    logic [1:0] sda_s;
  } dmsrp_host_t;
  // Registers taking a single data byte.
  function automatic logic dmsrp_narrow(input logic [7:0] sub);
    dmsrp_narrow = (sub == `DMSRP_SUB_NARROW_A) || (sub == `DMSRP_SUB_NARROW_B) ||
                   (sub == `DMSRP_SUB_NARROW_C) || (sub == `DMSRP_SUB_NARROW_D);
  endfunction : dmsrp_narrow
endpackage : dmsrp_pkg
`default_nettype wire

// >>> src/dmsrp_if.sv
// Pin bundle between controller and device, with open-drain data resolution.
`timescale 1ns/10ps
`default_nettype none
interface dmsrp_if;
  logic scl; // Serial clock, driven by the controller.
  logic en_n; // Three-wire enable, active low.
  logic mode_sel; // Protocol select: low two-wire, high three-wire.
  logic sda_host_out; // Controller data output value, always low.
  logic sda_host_oe; // Controller pulls data low while high.
  logic sda_dev_out; // Device data output value, always low.
  logic sda_dev_oe; // Device pulls data low while high.
  logic sda; // Resolved data level; pull-up gives high when nobody pulls.
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));
  modport dev (input scl, en_n, mode_sel, sda, output sda_dev_out, sda_dev_oe);
  modport host (output scl, en_n, mode_sel, sda_host_out, sda_host_oe, input sda);
endinterface : dmsrp_if
`default_nettype wire

// >>> src/dmsrp_cond.sv
// Start and stop detector clocked by the data line edges themselves.
`timescale 1ns/10ps
`default_nettype none
module dmsrp_cond (
  input wire logic sda, // Resolved data line level.
  input wire logic scl, // Serial clock level.
  input wire logic rst_n, // Asynchronous reset, active low.
  output logic start_tog, // Flips on every start event.
  output logic stop_tog // Flips on every stop event.
);
  // Falling data while the clock is high marks a start. A toggle is used so the
  // serial-clock domain can see the event without a free-running clock.
  // start on falling data
  always_ff @(negedge sda or negedge rst_n) begin
    if (!rst_n) begin
      start_tog <= 1'b0;
    end else if (scl) begin
      start_tog <= ~start_tog;
    end
  end
  // Rising data while the clock is high marks a stop.
  // stop on rising data
  always_ff @(posedge sda or negedge rst_n) begin
    if (!rst_n) begin
      stop_tog <= 1'b0;
    end else if (scl) begin
      stop_tog <= ~stop_tog;
    end
  end
endmodule : dmsrp_cond
`default_nettype wire

// >>> src/dmsrp_dev.sv
// Device end: serial register port in two-wire and three-wire mode.
`timescale 1ns/10ps
`default_nettype none
`include "dmsrp_params.svh"
// Operation
// - Select pin low two-wire, high three-wire
// - Serial clock alone runs the port
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop, idle
// - Receiver pulls data low in ninth clock
// - Address 1110000 then read/write bit
// - Write: address, subaddress 00h-0Fh, data, stop; subaddresses 09h-0Ch are refused
// - Read: address, subaddress, restart, read address
// - Controller releases line, no-acknowledge after read
// - Data line only pulled low, never driven
// - Three-wire active only while enable low
// - Three-wire data changes while clock low
// - Three-wire first byte is subaddress
// - Three-wire write commits on enable rise
// - Three-wire read shifts eight bits out
// - 03h,08h,0Dh,0Eh take one byte
module dmsrp_dev
  import dmsrp_pkg::*;
(
  input wire logic REF_CLK, // System clock for the register side.
  input wire logic RESET_N, // Asynchronous reset, active low.
  dmsrp_if.dev BUS, // Serial pins.
  input wire logic [7:0] STATUS_IN, // Status register value, read at 80h.
  input wire logic [7:0] ADC_IN, // Converter register value, read at 81h.
  output logic WR_STROBE, // One-cycle pulse when a write is committed.
  output logic [3:0] WR_ADDR, // Subaddress of the committed write.
  output logic [15:0] WR_DATA, // Committed data, narrow values in the low byte.
  output logic WR_WIDE // High when the committed register is 16 bits wide.
);
  dmsrp_dlink_t l_r; // Serial-clock domain state.
  dmsrp_dlink_t l_nxt; // Its next value.
  dmsrp_dref_t r_r; // Reference-clock domain state.
  dmsrp_dref_t r_nxt; // Its next value.
  logic oe_r; // Data pull-down, changed on falling serial clock.
  logic start_tog; // Start event toggle.
  logic stop_tog; // Stop event toggle.
  logic en_tog; // Flips each time the three-wire enable falls.
  logic three; // Three-wire mode selected.
  logic bit_in; // Data bit taken at this rising clock.
  logic [7:0] byte_in; // Byte completed by this bit.
  logic [7:0] rsel; // Read value chosen by the subaddress.

  dmsrp_cond u_cond (
    .sda(BUS.sda),
    .scl(BUS.scl),
    .rst_n(RESET_N),
    .start_tog(start_tog),
    .stop_tog(stop_tog)
  );

  assign three = BUS.mode_sel;
  assign bit_in = BUS.sda;
  assign byte_in = {l_r.sh[6:0], bit_in};
  assign rsel = (l_r.sub == `DMSRP_SUB_ADC) ? l_r.stat_s2[7:0] : l_r.stat_s2[15:8];

  // A controller need not clock while disabled, so the falling enable itself
  // is recorded; the next rising clock then opens a fresh three-wire frame.
  // enable fall opens frame
  always_ff @(negedge BUS.en_n or negedge RESET_N) begin
    if (!RESET_N) begin
      en_tog <= 1'b0;
    end else begin
      en_tog <= ~en_tog;
    end
  end

  // Link logic: all decisions are made on the rising serial clock, with no
  // internal clock, so the port works while the rest of the chip sleeps.
  always_comb begin
    l_nxt = l_r;
    l_nxt.stat_s1 = {STATUS_IN, ADC_IN};
    l_nxt.stat_s2 = l_r.stat_s1;
    l_nxt.start_seen = start_tog;
    l_nxt.stop_seen = stop_tog;
    l_nxt.en_seen = en_tog;
    l_nxt.plan = 1'b0;
    if (three && BUS.en_n) begin
      l_nxt.st = D_IDLE;
      l_nxt.bitc = 4'h0;
    end else if (three && (en_tog != l_r.en_seen)) begin
      l_nxt.st = D_SUB;
      l_nxt.sh = {7'h00, bit_in};
      l_nxt.bitc = 4'h1;
    end else if (!three && (start_tog != l_r.start_seen)) begin
      // This rising edge carries the first address bit.
      l_nxt.st = D_ADDR;
      l_nxt.sh = {7'h00, bit_in};
      l_nxt.bitc = 4'h1;
    end else if (!three && (stop_tog != l_r.stop_seen)) begin
      l_nxt.st = D_IDLE;
      l_nxt.bitc = 4'h0;
    end else if (l_r.st == D_IDLE) begin
      if (three) begin
        l_nxt.st = D_SUB;
        l_nxt.sh = {7'h00, bit_in};
        l_nxt.bitc = 4'h1;
      end
    end else if (l_r.st == D_RACK) begin
      // Acknowledge slot over; put out the first read bit.
      l_nxt.rd = rsel;
      l_nxt.plan = ~rsel[7];
      l_nxt.st = D_READ;
      l_nxt.bitc = 4'h0;
    end else if (l_r.st == D_READ) begin
      if (l_r.bitc < `DMSRP_LAST_BIT) begin
        l_nxt.plan = ~l_r.rd[6];
        l_nxt.rd = {l_r.rd[6:0], 1'b0};
        l_nxt.bitc = l_r.bitc + 4'h1;
      end else if (l_r.bitc == `DMSRP_LAST_BIT && !three) begin
        l_nxt.bitc = `DMSRP_BYTE_BITS;
      end else begin
        l_nxt.st = D_DONE;
        l_nxt.bitc = 4'h0;
      end
    end else if (l_r.bitc == `DMSRP_BYTE_BITS) begin
      // Acknowledge slot of a received byte ends; release the line.
      l_nxt.bitc = 4'h0;
    end else if (l_r.bitc < `DMSRP_LAST_BIT) begin
      l_nxt.sh = byte_in;
      l_nxt.bitc = l_r.bitc + 4'h1;
    end else begin
      // Byte complete; two-wire mode then has an acknowledge slot.
      l_nxt.sh = byte_in;
      l_nxt.bitc = three ? 4'h0 : `DMSRP_BYTE_BITS;
      case (l_r.st)
        D_ADDR: begin
          if (byte_in[7:1] == `DMSRP_DEV_ADDR) begin
            l_nxt.plan = 1'b1;
            l_nxt.st = byte_in[0] ? D_RACK : D_SUB;
          end else begin
            l_nxt.st = D_IDLE;
            l_nxt.bitc = 4'h0;
          end
        end
        D_SUB: begin
          l_nxt.sub = byte_in;
          l_nxt.nb = 1'b0;
          if (byte_in <= `DMSRP_SUB_LAST_WR &&
              !(byte_in >= `DMSRP_SUB_HOLE_LO && byte_in <= `DMSRP_SUB_HOLE_HI)) begin
            l_nxt.plan = !three;
            l_nxt.st = D_WDATA;
          end else if (byte_in == `DMSRP_SUB_STATUS || byte_in == `DMSRP_SUB_ADC) begin
            if (three) begin
              l_nxt.rd = (byte_in == `DMSRP_SUB_ADC) ? l_r.stat_s2[7:0] : l_r.stat_s2[15:8];
              l_nxt.plan = (byte_in == `DMSRP_SUB_ADC) ? ~l_r.stat_s2[7] : ~l_r.stat_s2[15];
              l_nxt.st = D_READ;
            end else begin
              l_nxt.plan = 1'b1;
              l_nxt.st = D_DONE;
            end
          end else begin
            l_nxt.st = D_DONE;
            l_nxt.bitc = 4'h0;
          end
        end
        D_WDATA: begin
          l_nxt.plan = !three;
          if (dmsrp_narrow(l_r.sub) || l_r.nb) begin
            l_nxt.h_addr = l_r.sub[3:0];
            l_nxt.h_wide = l_r.nb;
            l_nxt.h_data = l_r.nb ? {l_r.hi, byte_in} : {8'h00, byte_in};
            l_nxt.wr_tog = ~l_r.wr_tog;
            l_nxt.st = D_DONE;
          end else begin
            l_nxt.hi = byte_in;
            l_nxt.nb = 1'b1;
          end
        end
        default: begin
          // Surplus bytes are not acknowledged.
          l_nxt.bitc = 4'h0;
        end
      endcase
    end
  end

  // Rising serial clock registers the link state.
  // serial clock alone
  always_ff @(posedge BUS.scl or negedge RESET_N) begin
    if (!RESET_N) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // The pull-down changes only on the falling clock, so data moves while the
  // clock is low and can never be read as a start or stop.
  // change while clock low
  always_ff @(negedge BUS.scl or negedge RESET_N) begin
    if (!RESET_N) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= l_r.plan;
    end
  end

  assign BUS.sda_dev_out = 1'b0;
  assign BUS.sda_dev_oe = oe_r && !(three && BUS.en_n);

  // Register side: the write toggle and the pins are brought over with two
  // flip-flops; the held word is stable long before the toggle is seen.
  always_comb begin
    r_nxt = r_r;
    r_nxt.tog_s = {r_r.tog_s[1:0], l_r.wr_tog};
    r_nxt.en_s = {r_r.en_s[0], BUS.en_n};
    r_nxt.mode_s = {r_r.mode_s[0], BUS.mode_sel};
    r_nxt.strobe = 1'b0;
    if (r_r.tog_s[2] != r_r.tog_s[1]) begin
      r_nxt.pend = 1'b1;
      r_nxt.addr = l_r.h_addr;
      r_nxt.data = l_r.h_data;
      r_nxt.wide = l_r.h_wide;
    end else if (r_r.pend && (!r_r.mode_s[1] || r_r.en_s[1])) begin
      r_nxt.pend = 1'b0;
      r_nxt.strobe = 1'b1;
    end
  end

  // Reference clock registers the register-side state.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign WR_STROBE = r_r.strobe;
  assign WR_ADDR = r_r.addr;
  assign WR_DATA = r_r.data;
  assign WR_WIDE = r_r.wide;
endmodule : dmsrp_dev
`default_nettype wire

// >>> src/dmsrp_host.sv
// Controller end: sequences register reads and writes onto the serial pins.
`timescale 1ns/10ps
`default_nettype none
`include "dmsrp_params.svh"
module dmsrp_host
  import dmsrp_pkg::*;
#(
  parameter int QUARTER = `DMSRP_QUARTER_CYC // Reference cycles per quarter bit.
) (
  input wire logic REF_CLK, // System clock.
  input wire logic RESET_N, // Asynchronous reset, active low.
  dmsrp_if.host BUS, // Serial pins.
  input wire logic MODE_SEL, // Protocol for next command: 0 two-wire, 1 three-wire.
  input wire logic CMD_VALID, // Command request.
  output logic CMD_READY, // Command taken when both high.
  input wire logic CMD_READ, // 1 read, 0 write.
  input wire logic [7:0] CMD_SUB, // Subaddress.
  input wire logic [15:0] CMD_DATA, // Write data, narrow in low byte.
  output logic RSP_VALID, // One-cycle pulse when the command ends.
  output logic [7:0] RSP_DATA, // Read byte.
  output logic RSP_NACK // Device refused a byte.
);
  localparam logic [7:0] QMAX = 8'(QUARTER - 1); // Last tick of a quarter.
  localparam logic [7:0] AW = {`DMSRP_DEV_ADDR, 1'b0}; // Write address byte.
  localparam logic [7:0] AR = {`DMSRP_DEV_ADDR, 1'b1}; // Read address byte.
  dmsrp_host_t s_r; // Controller state.
  dmsrp_host_t s_nxt; // Its next value.
  logic rx_byte; // Current byte comes from the device.
  logic last_slot; // Current bit slot ends the byte.
  logic [3:0] slot_end; // Index of the final slot.

  assign rx_byte = s_r.isrd && (s_r.bi == s_r.nbytes - 3'h1);
  assign slot_end = s_r.mode ? `DMSRP_LAST_BIT : `DMSRP_BYTE_BITS;
  assign last_slot = (s_r.bitc == slot_end);

  // Sequencer: four quarter phases per bit; clock low in the first half.
  always_comb begin
    s_nxt = s_r;
    s_nxt.sda_s = {s_r.sda_s[0], BUS.sda};
    s_nxt.rsp_valid = 1'b0;
    s_nxt.tick = s_r.tick + 8'h01;
    if (s_r.st == H_IDLE) begin
      s_nxt.tick = 8'h00;
      s_nxt.q = 2'h0;
      if (CMD_VALID) begin
        s_nxt.mode = MODE_SEL;
        s_nxt.isrd = CMD_READ;
        s_nxt.nack = 1'b0;
        s_nxt.bi = 3'h0;
        s_nxt.bitc = 4'h0;
        s_nxt.st = H_START;
        if (MODE_SEL) begin
          s_nxt.bytes = CMD_READ ? {CMD_SUB, 24'h0} :
                        dmsrp_narrow(CMD_SUB) ? {CMD_SUB, CMD_DATA[7:0], 16'h0} :
                        {CMD_SUB, CMD_DATA, 8'h0};
          s_nxt.nbytes = (CMD_READ || dmsrp_narrow(CMD_SUB)) ? 3'h2 : 3'h3;
        end else begin
          s_nxt.bytes = CMD_READ ? {AW, CMD_SUB, AR, 8'h0} :
                        dmsrp_narrow(CMD_SUB) ? {AW, CMD_SUB, CMD_DATA[7:0], 8'h0} :
                        {AW, CMD_SUB, CMD_DATA};
          s_nxt.nbytes = (!CMD_READ && dmsrp_narrow(CMD_SUB)) ? 3'h3 : 3'h4;
        end
      end
    end else if (s_r.tick == QMAX) begin
      s_nxt.tick = 8'h00;
      s_nxt.q = s_r.q + 2'h1;
      case (s_r.st)
        H_START: begin
          if (s_r.mode) begin
            s_nxt.en_n = 1'b0;
            // Clock stays high until enabled, then falls before the first bit.
            s_nxt.scl = (s_r.q != 2'h3);
          end else begin
            // start: data falls, clock high
            // The clock falls again at the end, so the first bit starts low.
            s_nxt.scl = (s_r.q == 2'h1) || (s_r.q == 2'h2);
            s_nxt.pull = (s_r.q >= 2'h2);
          end
          if (s_r.q == 2'h3) begin
            s_nxt.st = H_BIT;
          end
        end
        H_BIT: begin
          // The clock falls at the end of a bit and rises mid-bit; data set in
          // between never moves in the same step as a clock edge, which the
          // device would otherwise read as a start or stop.
          // data moves while clock low
          s_nxt.scl = (s_r.q == 2'h1) || (s_r.q == 2'h2);
          if (s_r.q == 2'h0) begin
            s_nxt.pull = !(rx_byte || s_r.bitc == `DMSRP_BYTE_BITS) && !s_r.bytes[31];
          end
          if (s_r.q == 2'h3) begin
            if (rx_byte && s_r.bitc < `DMSRP_BYTE_BITS) begin
              s_nxt.rx = {s_r.rx[6:0], s_r.sda_s[1]};
            end
            if (!rx_byte && s_r.bitc == `DMSRP_BYTE_BITS && s_r.sda_s[1]) begin
              s_nxt.nack = 1'b1;
            end
            s_nxt.bitc = s_r.bitc + 4'h1;
            if (s_r.bitc < `DMSRP_BYTE_BITS) begin
              s_nxt.bytes = {s_r.bytes[30:0], 1'b0};
            end
            if (last_slot) begin
              s_nxt.bitc = 4'h0;
              s_nxt.bi = s_r.bi + 3'h1;
              if ((s_nxt.nack) || (s_r.bi + 3'h1 == s_r.nbytes)) begin
                s_nxt.st = H_STOP;
              end else if (!s_r.mode && s_r.isrd && s_r.bi == 3'h1) begin
                s_nxt.st = H_START;
              end
            end
          end
        end
        H_STOP: begin
          if (s_r.mode) begin
            s_nxt.en_n = (s_r.q >= 2'h2);
          end else begin
            s_nxt.scl = (s_r.q != 2'h0);
            s_nxt.pull = (s_r.q < 2'h2);
          end
          if (s_r.q == 2'h3) begin
            s_nxt.st = H_IDLE;
            s_nxt.scl = 1'b1;
            s_nxt.pull = 1'b0;
            s_nxt.en_n = 1'b1;
            s_nxt.rsp_valid = 1'b1;
            s_nxt.rsp_data = s_r.rx;
            s_nxt.rsp_nack = s_nxt.nack;
          end
        end
        default: begin
          s_nxt.st = H_IDLE;
        end
      endcase
    end
  end

  // One register stage holds the whole controller state.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r <= '{st: H_IDLE, scl: 1'b1, en_n: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign CMD_READY = (s_r.st == H_IDLE);
  assign RSP_VALID = s_r.rsp_valid;
  assign RSP_DATA = s_r.rsp_data;
  assign RSP_NACK = s_r.rsp_nack;
  assign BUS.scl = s_r.scl;
  assign BUS.en_n = s_r.en_n;
  assign BUS.mode_sel = s_r.mode;
  assign BUS.sda_host_out = 1'b0;
  assign BUS.sda_host_oe = s_r.pull;
endmodule : dmsrp_host
`default_nettype wire

// >>> test/dmsrp_chk.sv
// Checker of the serial pins between the controller and device ends.
`timescale 1ns/10ps
`default_nettype none
module dmsrp_chk #(
  parameter int QUARTER = 25 // Reference cycles per quarter bit.
) (
  input wire logic REF_CLK, // Reference clock.
  input wire logic RESET_N, // Reset, active low.
  input wire logic scl, // Serial clock.
  input wire logic en_n, // Three-wire enable, active low.
  input wire logic mode_sel, // Protocol select.
  input wire logic sda_host_out, // Controller data value.
  input wire logic sda_host_oe, // Controller pull enable.
  input wire logic sda_dev_out, // Device data value.
  input wire logic sda_dev_oe, // Device pull enable.
  input wire logic sda // Resolved data level.
);
  // The address acknowledge falls some 33 quarters after a start; the margin covers skew.
  localparam int ACK_LO = 28 * QUARTER;
  localparam int ACK_HI = 40 * QUARTER;
  // The serial clock is paced by the reference clock, so one sampling clock serves.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  property p_pull; (sda_dev_oe |-> !sda_dev_out) and (sda_host_oe |-> !sda_host_out); endproperty
  a_pull: assert property (p_pull) else $error("Data line driven high.");
  property p_tw_hold; !mode_sel && scl && $past(scl) |-> $stable(sda_dev_oe); endproperty
  a_tw_hold: assert property (p_tw_hold) else $error("Device data moved, clock high.");
  property p_thr_hold; mode_sel && !en_n && scl && $past(scl) |-> $stable(sda_dev_oe); endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("Device bit moved, clock high.");
  property p_host_hold; mode_sel && !en_n && !$past(en_n) && scl && $past(scl)
    |-> $stable(sda_host_oe); endproperty
  a_host_hold: assert property (p_host_hold) else $error("Controller bit moved.");
  property p_en_quiet; mode_sel && en_n && $past(en_n, 8) |-> !sda_dev_oe; endproperty
  a_en_quiet: assert property (p_en_quiet) else $error("Device active, enable high.");
  property p_stop_idle; !mode_sel && scl && $past(scl) && $rose(sda) |=> !sda_dev_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Device busy after stop.");
  property p_start_ack; !mode_sel && scl && $past(scl) && $fell(sda)
    |-> ##[ACK_LO:ACK_HI] sda_dev_oe; endproperty
  a_start_ack: assert property (p_start_ack) else $error("Address not acknowledged.");
  property p_mode_idle; $changed(mode_sel) |-> scl && en_n && !sda_dev_oe; endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("Protocol changed in a frame.");
endmodule : dmsrp_chk
`default_nettype wire

// >>> test/dual_mode_serial_reg_port_tb_top.sv
// Bench joining the controller and device ends over the serial pins.
`timescale 1ns/10ps
`default_nettype none
module dual_mode_serial_reg_port_tb_top;
  localparam int QTR = 3; // Short quarter keeps frames brief.
  logic ref_clk = 1'b0; // Reference clock.
  logic reset_n; // Shared reset, active low; its first fall fires every async reset.
  logic mode_sel = 1'b0; // Protocol of the next command.
  logic cmd_valid = 1'b0; // Command request.
  logic cmd_read = 1'b0; // Read when high.
  logic [7:0] cmd_sub = 8'h00; // Subaddress.
  logic [15:0] cmd_data = 16'h0000; // Write data.
  logic [7:0] status_in = 8'h00; // Status value.
  logic [7:0] adc_in = 8'h00; // Converter value.
  logic cmd_ready, rsp_valid, rsp_nack, wr_strobe, wr_wide, got_wide; // Observed flags.
  logic [7:0] rsp_data; // Read byte.
  logic [3:0] wr_addr, got_addr; // Committed address and its copy.
  logic [15:0] wr_data, got_data; // Committed data and its copy.
  int n_mismatch = 0; // Mismatches seen.
  int cmp_count = 0; // Comparisons made.
  int n_wr = 0; // Commits seen.
  logic [7:0] wr_tbl [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h0d, 8'h0e, 8'h0f}; // Every writable subaddress.
  dmsrp_if bus();
  always #5 ref_clk = ~ref_clk;
  dmsrp_dev i_dmsrp_dev (.REF_CLK(ref_clk), .RESET_N(reset_n), .BUS(bus), .STATUS_IN(status_in),
    .ADC_IN(adc_in), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
    .WR_WIDE(wr_wide));
  dmsrp_host #(.QUARTER(QTR)) i_dmsrp_host (.REF_CLK(ref_clk), .RESET_N(reset_n), .BUS(bus),
    .MODE_SEL(mode_sel), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_READ(cmd_read),
    .CMD_SUB(cmd_sub), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_NACK(rsp_nack));
  dmsrp_chk #(.QUARTER(QTR)) i_dmsrp_chk (.REF_CLK(ref_clk), .RESET_N(reset_n), .scl(bus.scl),
    .en_n(bus.en_n), .mode_sel(bus.mode_sel), .sda_host_out(bus.sda_host_out),
    .sda_host_oe(bus.sda_host_oe), .sda_dev_out(bus.sda_dev_out),
    .sda_dev_oe(bus.sda_dev_oe), .sda(bus.sda));
  // Keep a copy of each commit, since the strobe lasts one cycle only.
  always @(posedge ref_clk) begin
    if (wr_strobe === 1'b1) begin
      n_wr <= n_wr + 1;
      got_addr <= wr_addr;
      got_data <= wr_data;
      got_wide <= wr_wide;
    end
  end
  // Narrow registers carry their byte low with the upper byte cleared.
  function automatic logic [15:0] exp_data(input logic [7:0] s, input logic [15:0] d);
    case (s)
      8'h03, 8'h08, 8'h0d, 8'h0e: exp_data = {8'h00, d[7:0]};
      default: exp_data = d;
    endcase
  endfunction : exp_data
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // Requests are held until taken; the answer is awaited under a bound.
  task automatic run_cmd(input logic m, input logic rd, input logic [7:0] s,
    input logic [15:0] d);
    int k;
    @(negedge ref_clk);
    mode_sel = m;
    cmd_read = rd;
    cmd_sub = s;
    cmd_data = d;
    cmd_valid = 1'b1;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    check({15'h0, rsp_valid}, 16'h0001);
  endtask : run_cmd
  // A commit crosses a synchroniser, so allow a short bounded wait.
  task automatic wait_wr(input int n0);
    int k;
    k = 0;
    while (n_wr == n0 && k < 60) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : wait_wr
  initial begin
    logic [15:0] d;
    logic [7:0] s;
    int n0;
    reset_n = 1'b0;
    n0 = $urandom(91132);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    // Every writable subaddress in both protocols, back to back, full-scale data first.
    for (int i = 0; i < 24; i++) begin
      s = wr_tbl[i % 12];
      d = (i == 0) ? 16'hffff : 16'($urandom);
      n0 = n_wr;
      run_cmd(i >= 12, 1'b0, s, d);
      wait_wr(n0);
      check({15'h0, n_wr == n0 + 1}, 16'h0001);
      check({12'h0, got_addr}, {12'h0, s[3:0]});
      check(got_data, exp_data(s, d));
      check({15'h0, got_wide}, {15'h0, exp_data(s, 16'hffff) == 16'hffff});
      if (i < 12) check({15'h0, rsp_nack}, 16'h0000);
    end
    $display("Write test done");
    // Both status registers in both protocols with random contents.
    for (int i = 0; i < 8; i++) begin
      status_in = 8'($urandom);
      adc_in = 8'($urandom);
      s = i[0] ? 8'h81 : 8'h80;
      run_cmd(i[1], 1'b1, s, 16'h0000);
      check({8'h00, rsp_data}, {8'h00, i[0] ? adc_in : status_in});
      if (!i[1]) check({15'h0, rsp_nack}, 16'h0000);
    end
    $display("Read test done");
    // A hole and an out-of-range subaddress are refused and never committed.
    for (int i = 0; i < 4; i++) begin
      s = i[0] ? 8'h0a : 8'h10;
      n0 = n_wr;
      run_cmd(i[1], 1'b0, s, 16'($urandom));
      wait_wr(n0);
      check({15'h0, n_wr == n0}, 16'h0001);
      if (!i[1]) check({15'h0, rsp_nack}, 16'h0001);
    end
    $display("Refusal test done");
    complete_run();
  end
  // The tests need about an eighth of a millisecond; this cuts a hang short.
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end
endmodule : dual_mode_serial_reg_port_tb_top
`default_nettype wire
